// [dpcd_pkg.sv]
// Constants and types shared by the digital pot command decoder
`default_nettype none
package dpcd_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int WIPER_BITS = 10;
    localparam int WORD_BITS = 16;
    localparam int NV_WORDS = 16;
    localparam logic [9:0] WIPER_FULL = 10'h3ff;
    localparam logic [9:0] WIPER_MID = 10'h200;
    localparam logic [9:0] WIPER_ONE = 10'h001;
    localparam logic [15:0] NV_WORD0_RESET = 16'h0200;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_RESTORE = 4'h1;
    localparam logic [3:0] CMD_STORE = 4'h2;
    localparam logic [3:0] CMD_WRITE_NV = 4'h3;
    localparam logic [3:0] CMD_SHR_A = 4'h4;
    localparam logic [3:0] CMD_SHR = 4'h5;
    localparam logic [3:0] CMD_DEC_A = 4'h6;
    localparam logic [3:0] CMD_DEC = 4'h7;
    localparam logic [3:0] CMD_RELOAD = 4'h8;
    localparam logic [3:0] CMD_READ_NV = 4'h9;
    localparam logic [3:0] CMD_READ_WIPER = 4'ha;
    localparam logic [3:0] CMD_WRITE_WIPER = 4'hb;
    localparam logic [3:0] CMD_SHL_A = 4'hc;
    localparam logic [3:0] CMD_SHL = 4'hd;
    localparam logic [3:0] CMD_INC_A = 4'he;
    localparam logic [3:0] CMD_INC = 4'hf;
    typedef enum logic [1:0] {DPCD_PWR_IDLE, DPCD_PWR_READ} dpcd_pwr_e;
endpackage
`default_nettype wire

// [dpcd_sync.sv]
// Two-flop level synchroniser
`default_nettype none
`timescale 1ns/100ps
module dpcd_sync #(parameter int WIDTH = 1) (
    input wire logic clk_i, // Destination clock
    input wire logic rst_i, // Async reset, active high
    input wire logic [WIDTH-1:0] d_i, // Foreign level
    output logic [WIDTH-1:0] q_o // Synchronised level
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Resets to ones: chip select and the open-drain data level both idle high
            meta <= '1;
            q_o <= '1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // dpcd_sync
`default_nettype wire

// [dpcd_link.sv]
// Serial link side: frame shifter and readback substitution on the link clock
`default_nettype none
`timescale 1ns/100ps
module dpcd_link
    import dpcd_pkg::*;
(
    input wire logic sclk_i, // Serial clock from host
    input wire logic rst_i, // Async reset, active high
    input wire logic cs_n_i, // Chip select, active low
    input wire logic sdi_i, // Serial data in
    input wire logic ld_en_i, // Readback word ready (system clock level, used without a synchroniser)
    input wire logic [15:0] ld_word_i, // Readback word, stable while ld_en_i
    output logic [23:0] shreg_o, // Shift register contents
    output logic [7:0] nbits_o, // Running count of selected clock edges
    output logic sdo_o // Serial data out, msb of shift register
);
    logic first_done;
    // Readback word is loaded on the first edge of the frame after a read.
    // ld_en_i and ld_word_i only change a few system clocks after chip select
    // rises, so they have long settled when the next frame's first edge comes;
    // a flop synchroniser on this clock would miss them, as it stops between frames.
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            shreg_o <= '0;
        end else if (!cs_n_i) begin
            if (ld_en_i && !first_done) begin
                shreg_o <= {shreg_o[22:16], ld_word_i, sdi_i};
            end else begin
                shreg_o <= {shreg_o[22:0], sdi_i};
            end
        end
    end
    // First-edge marker is cleared by chip select, since the clock stops between frames
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            first_done <= 1'b0;
        end else begin
            first_done <= 1'b1;
        end
    end
    // Count is never cleared by chip select, so it survives until the system
    // side has captured it; frame length is the difference of two captures.
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            nbits_o <= 8'h00;
        end else if (!cs_n_i) begin
            nbits_o <= nbits_o + 8'h01;
        end
    end
    assign sdo_o = shreg_o[23];
endmodule // dpcd_link
`default_nettype wire

// [dpcd_top.sv]
// Command decoder for a serial nonvolatile digital potentiometer
`default_nettype none
`timescale 1ns/100ps
module dpcd_top
    import dpcd_pkg::*;
#(
    parameter logic [15:0] NV_WORD0_INIT = NV_WORD0_RESET // Stored wiper at power-on
) (
    input wire logic mclk_i, // System clock, 200 MHz
    input wire logic rst_i, // Power-on reset, active high
    input wire logic sclk_i, // Serial clock from host
    input wire logic cs_n_i, // Chip select, active low
    input wire logic sdi_i, // Serial data in
    output logic sdo_o, // Serial data out value (open drain low drive)
    output logic sdo_oe_o, // Serial data out enable, high while driving
    output logic [9:0] wiper_o, // Wiper code register
    output logic read_power_o, // Device in read power state
    output logic [3:0] last_cmd_o // Last executed command
);
    logic [23:0] shreg;
    logic [7:0] nbits;
    logic link_sdo;
    logic [9:0] wiper_code_register;
    logic [15:0] nonvolatile_word_store [NV_WORDS];
    logic [23:0] prev_frame;
    logic prev_valid;
    logic readback_pend;
    logic [15:0] readback_word;
    logic [7:0] nbits_base;
    logic [7:0] flen;
    logic cs_n_sync;
    logic cs_n_q;
    logic [23:0] frame_m;
    logic [23:0] frame_s;
    logic [7:0] nbits_m;
    logic [7:0] nbits_s;
    logic sdo_s;
    logic cs_rise;
    logic exec;
    logic [23:0] frame;
    logic [3:0] command_field;
    logic [3:0] address_field;
    logic [15:0] data_field;
    dpcd_pwr_e pwr;

    function automatic logic [9:0] shift_up(input logic [9:0] v);
        if (v == 10'h000) begin
            return WIPER_ONE;
        end else if (v >= WIPER_MID) begin
            return WIPER_FULL;
        end else begin
            return {v[8:0], 1'b0};
        end
    endfunction

    // Commands 1,2,4,6,10,11,12,14 need address zero; the rest take any
    function automatic logic cmd_taken(input logic [3:0] cmd, input logic [3:0] addr);
        case (cmd)
            CMD_NOP, CMD_WRITE_NV, CMD_SHR, CMD_DEC, CMD_RELOAD, CMD_READ_NV, CMD_SHL, CMD_INC: begin
                return 1'b1;
            end
            default: begin
                return addr == 4'h0;
            end
        endcase
    endfunction

    dpcd_link u_link (
        .sclk_i(sclk_i),
        .rst_i(rst_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .ld_en_i(readback_pend),
        .ld_word_i(readback_word),
        .shreg_o(shreg),
        .nbits_o(nbits),
        .sdo_o(link_sdo)
    );

    dpcd_sync #(.WIDTH(1)) u_cs_sync (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(cs_n_i),
        .q_o(cs_n_sync)
    );

    // Open-drain data level back onto the system clock
    dpcd_sync #(.WIDTH(1)) u_sdo_sync (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(link_sdo),
        .q_o(sdo_s)
    );

    // Shifter words are static while chip select is high, so a plain two-flop
    // capture after the synchronised rising edge sees settled values.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_m <= '0;
            frame_s <= '0;
            nbits_m <= '0;
            nbits_s <= '0;
            cs_n_q <= 1'b1;
        end else begin
            frame_m <= shreg;
            frame_s <= frame_m;
            nbits_m <= nbits;
            nbits_s <= nbits_m;
            cs_n_q <= cs_n_sync;
        end
    end

    assign cs_rise = cs_n_sync && !cs_n_q;

    // Wait two more cycles so the frame capture has settled
    logic [1:0] rise_dly;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_dly <= 2'b00;
        end else begin
            rise_dly <= {rise_dly[0], cs_rise};
        end
    end
    assign exec = rise_dly[1];

    assign flen = nbits_s - nbits_base;

    always_comb begin
        if (flen == 8'h00 && prev_valid) begin
            frame = prev_frame;
        end else begin
            frame = frame_s;
        end
    end
    assign command_field = frame[CMD_MSB:CMD_LSB];
    assign address_field = frame[ADDR_MSB:ADDR_LSB];
    // data only read by write commands
    assign data_field = frame[WORD_BITS-1:0];

    // Any count that is a nonzero multiple of 24 is a full frame; zero repeats the last taken frame; others drop
    logic frame_ok;
    always_comb begin
        frame_ok = 1'b0;
        if (flen == 8'h00) begin
            frame_ok = prev_valid;
        end else begin
            frame_ok = (flen % 8'd24) == 8'h00;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_frame <= '0;
            prev_valid <= 1'b0;
            last_cmd_o <= CMD_NOP;
            nbits_base <= 8'h00;
        end else if (exec) begin
            // Edge count at this frame end is the base for the next length
            nbits_base <= nbits_s;
            // Refused commands never become the one a bare pulse repeats
            if (frame_ok && cmd_taken(command_field, address_field)) begin
                prev_frame <= frame;
                prev_valid <= 1'b1;
                last_cmd_o <= command_field;
            end
        end
    end

    // Wiper register; power-on value comes from word zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wiper_code_register <= NV_WORD0_INIT[9:0];
        end else if (exec && frame_ok) begin
            case (command_field)
                CMD_RESTORE: begin
                    if (address_field == 4'h0) begin
                        wiper_code_register <= nonvolatile_word_store[0][9:0];
                    end
                end
                CMD_RELOAD: wiper_code_register <= nonvolatile_word_store[0][9:0];
                CMD_WRITE_WIPER: begin
                    if (address_field == 4'h0) begin
                        wiper_code_register <= data_field[9:0];
                    end
                end
                CMD_SHR_A: begin
                    if (address_field == 4'h0) begin
                        wiper_code_register <= {1'b0, wiper_code_register[9:1]};
                    end
                end
                CMD_SHR: wiper_code_register <= {1'b0, wiper_code_register[9:1]};
                CMD_DEC_A, CMD_DEC: begin
                    if ((command_field == CMD_DEC || address_field == 4'h0) && wiper_code_register != 10'h000) begin
                        wiper_code_register <= wiper_code_register - 10'h001;
                    end
                end
                CMD_SHL_A, CMD_SHL: begin
                    if (command_field == CMD_SHL || address_field == 4'h0) begin
                        wiper_code_register <= shift_up(wiper_code_register);
                    end
                end
                CMD_INC_A, CMD_INC: begin
                    if ((command_field == CMD_INC || address_field == 4'h0) && wiper_code_register != WIPER_FULL) begin
                        wiper_code_register <= wiper_code_register + 10'h001;
                    end
                end
                default: wiper_code_register <= wiper_code_register;
            endcase
        end
    end

    // Nonvolatile store modelled as a register array
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NV_WORDS; i++) begin
                nonvolatile_word_store[i] <= (i == 0) ? NV_WORD0_INIT : 16'hffff;
            end
        end else if (exec && frame_ok) begin
            if (command_field == CMD_STORE && address_field == 4'h0) begin
                nonvolatile_word_store[0] <= {6'h00, wiper_code_register};
            end else if (command_field == CMD_WRITE_NV) begin
                if (address_field == 4'h0) begin
                    nonvolatile_word_store[0] <= {6'h00, data_field[9:0]};
                end else begin
                    nonvolatile_word_store[address_field] <= data_field;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr <= DPCD_PWR_IDLE;
        end else if (exec && frame_ok) begin
            case (command_field)
                CMD_NOP: pwr <= DPCD_PWR_IDLE;
                CMD_RESTORE: begin
                    if (address_field == 4'h0) begin
                        pwr <= DPCD_PWR_READ;
                    end
                end
                default: pwr <= pwr;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            readback_pend <= 1'b0;
            readback_word <= '0;
        end else if (exec) begin
            readback_pend <= 1'b0;
            if (frame_ok && command_field == CMD_READ_NV) begin
                readback_pend <= 1'b1;
                readback_word <= nonvolatile_word_store[address_field];
            end else if (frame_ok && command_field == CMD_READ_WIPER && address_field == 4'h0) begin
                readback_pend <= 1'b1;
                readback_word <= {6'h00, wiper_code_register};
            end
        end
    end

    // echo shifter msb; driven low only while selected
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            wiper_o <= NV_WORD0_INIT[9:0];
            read_power_o <= 1'b0;
        end else begin
            sdo_o <= 1'b0;
            sdo_oe_o <= !cs_n_sync && !sdo_s;
            wiper_o <= wiper_code_register;
            read_power_o <= (pwr == DPCD_PWR_READ);
        end
    end
endmodule // dpcd_top
`default_nettype wire

// [dpcd_top_properties.sv]
// Port checker for the pot command decoder
`timescale 1ns/100ps
`default_nettype none
module dpcd_top_properties
    import dpcd_pkg::*;
(
    input wire logic mclk_i, // System clock
    input wire logic rst_i, // Async reset
    input wire logic sclk_i, // Link clock
    input wire logic cs_n_i, // Chip select
    input wire logic sdi_i, // Serial data in
    input wire logic sdo_o, // Data out value
    input wire logic sdo_oe_o, // Data out enable
    input wire logic [9:0] wiper_o, // Wiper code
    input wire logic read_power_o, // Read power state
    input wire logic [3:0] last_cmd_o // Last command
);
    logic [23:0] sh;
    logic [7:0] tot, tf, cnt, age;
    logic [9:0] ws;
    logic cs_d, ev, ok;
    logic [3:0] c;
    // Free edge count; frame length is a difference, so no clear crosses domains
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            tot <= 8'h00;
            sh <= 24'h000000;
        end else if (!cs_n_i) begin
            tot <= tot + 8'h01;
            sh <= {sh[22:0], sdi_i};
        end
    end
    assign ev = cs_n_i && !cs_d;
    assign cnt = tot - tf;
    assign c = sh[23:20];
    assign ok = ev && cnt != 8'h00 && cnt % 24 == 0
        && (sh[19:16] == 4'h0 || c inside {4'h0, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hd, 4'hf});
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_d <= 1'b1;
            tf <= 8'h00;
            age <= 8'hff;
            ws <= 10'h000;
        end else begin
            cs_d <= cs_n_i;
            if (!cs_n_i && cs_d) begin
                tf <= tot;
            end
            if (ev) begin
                age <= 8'h00;
                ws <= wiper_o;
            end else if (age != 8'hff) begin
                age <= age + 8'h01;
            end
        end
    end
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_write;
        ok && c == CMD_WRITE_WIPER |-> ##[3:10] wiper_o == sh[9:0];
    endproperty
    a_write: assert property (p_write) else $error("wiper load wrong");
    property p_inc;
        ok && c[3:1] == 3'b111 |-> ##[3:10] wiper_o == ((ws == WIPER_FULL) ? ws : ws + 10'h001);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");
    property p_dec;
        ok && c[3:1] == 3'b011 |-> ##[3:10] wiper_o == ((ws == 10'h000) ? ws : ws - 10'h001);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
    property p_shl;
        ok && c[3:1] == 3'b110 |-> ##[3:10]
            wiper_o == ((ws == 10'h000) ? WIPER_ONE : (ws >= WIPER_MID) ? WIPER_FULL : ws << 1);
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");
    property p_shr;
        ok && c[3:1] == 3'b010 |-> ##[3:10] wiper_o == ws >> 1;
    endproperty
    a_shr: assert property (p_shr) else $error("right shift wrong");
    property p_rpon;
        ok && c == CMD_RESTORE |-> ##[3:10] read_power_o;
    endproperty
    a_rpon: assert property (p_rpon) else $error("read power not entered");
    property p_rpoff;
        ok && c == CMD_NOP |-> ##[3:10] !read_power_o;
    endproperty
    a_rpoff: assert property (p_rpoff) else $error("read power not left");
    property p_last;
        ok |-> ##[3:10] last_cmd_o == c;
    endproperty
    a_last: assert property (p_last) else $error("last command wrong");
    property p_quiet;
        !$stable(wiper_o) |-> age <= 8'd12;
    endproperty
    a_quiet: assert property (p_quiet) else $error("wiper moved without frame end");
    property p_refuse;
        ev && cnt % 24 != 0 |=> $stable(wiper_o) [*8];
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad length frame acted on");
endmodule // dpcd_top_properties
bind dpcd_top dpcd_top_properties chk (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .wiper_o(wiper_o),
    .read_power_o(read_power_o), .last_cmd_o(last_cmd_o));
`default_nettype wire

// [dpcd_host.sv]
// Serial host model that clocks frames into the decoder
`timescale 1ns/100ps
`default_nettype none
module dpcd_host (
    output logic sclk_o, // Link clock, idle low
    output logic cs_n_o, // Chip select
    output logic sdi_o, // Data to device
    input wire logic sdo_i // Resolved data line
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    task automatic send(input int n, input logic [47:0] f, output logic [23:0] rx);
        cs_n_o = 1'b0;
        #37.3;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = f[i];
            #40;
            rx = {rx[22:0], sdo_i};
            sclk_o = 1'b1;
            #40;
            sclk_o = 1'b0;
        end
        #40;
        cs_n_o = 1'b1;
        // Released line shows the inverse so a stale bit cannot pass
        sdi_o = !sdi_o;
        #250;
    endtask
endmodule // dpcd_host
`default_nettype wire

// [dpcd_top_bench.sv]
// Self-checking bench for the pot command decoder
`timescale 1ns/100ps
`default_nettype none
module dpcd_top_bench import dpcd_pkg::*;;
    localparam logic [15:0] W0 = 16'h0155;
    logic mclk_i, sclk, cs_n, sdi, sdo, sdo_oe, rpw;
    logic rst_i = 1'b1;
    logic [9:0] wiper, w;
    logic [3:0] lcmd, lc;
    logic [23:0] rx, prev, lastf;
    logic [15:0] nv [16];
    logic [15:0] rw, rm;
    logic rp = 1'b0, pv = 1'b0, rd = 1'b0, hl = 1'b0;
    logic [31:0] v;
    int errors = 0, checks = 0, seed = 57679;
    wire line = sdo_oe ? sdo : 1'b1;
    dpcd_top #(.NV_WORD0_INIT(W0)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .wiper_o(wiper), .read_power_o(rpw), .last_cmd_o(lcmd));
    dpcd_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(line));
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [9:0] step(input logic [3:0] c, input logic [9:0] x);
        case (c[3:1])
            3'b010: return x >> 1;
            3'b011: return (x == 10'h000) ? x : x - 10'h001;
            3'b110: return (x == 10'h000) ? 10'h001 : (x >= 10'h200) ? 10'h3ff : x << 1;
            default: return (x == 10'h3ff) ? x : x + 10'h001;
        endcase
    endfunction
    task automatic frame(input int n, input logic [47:0] f);
        logic [23:0] x;
        logic [3:0] c, a;
        x = (n == 0) ? lastf : f[23:0];
        c = x[23:20];
        a = x[19:16];
        host.send(n, f, rx);
        repeat (2) @(posedge mclk_i);
        if (rd && n == 24) chk("readback", {8'h00, rw & rm}, {8'h00, rx[15:0] & rm});
        else if (pv && n == 24) chk("echo", prev, rx);
        rd = 1'b0;
        if (n != 0) begin
            prev = f[23:0];
            pv = (n % 24 == 0);
        end
        if (n % 24 == 0 && (n != 0 || hl) && (a == 4'h0 || c inside {0, 3, 5, 7, 8, 9, 13, 15})) begin
            hl = 1'b1;
            lastf = x;
            lc = c;
            rm = (c == CMD_READ_WIPER || a == 4'h0) ? 16'h03ff : 16'hffff;
            case (c)
                CMD_NOP: rp = 1'b0;
                CMD_RESTORE: begin
                    w = nv[0][9:0];
                    rp = 1'b1;
                end
                CMD_STORE: nv[0] = {6'h00, w};
                CMD_WRITE_NV: nv[a] = x[15:0];
                CMD_RELOAD: w = nv[0][9:0];
                CMD_READ_NV: begin
                    rd = 1'b1;
                    rw = nv[a];
                end
                CMD_READ_WIPER: begin
                    rd = 1'b1;
                    rw = {6'h00, w};
                end
                CMD_WRITE_WIPER: w = x[9:0];
                default: w = step(c, w);
            endcase
        end
        chk("wiper", {14'h0, w}, {14'h0, wiper});
        chk("read_power", {23'h0, rp}, {23'h0, rpw});
        chk("last_cmd", {20'h0, lc}, {20'h0, lcmd});
    endtask
    initial begin
        #250000;
        errors++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 16; i++) nv[i] = 16'hffff;
        nv[0] = W0;
        w = W0[9:0];
        lc = 4'h0;
        repeat (3) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        chk("wiper_reset", {14'h0, W0[9:0]}, {14'h0, wiper});
        frame(24, 48'hb00000);
        frame(24, 48'h60ffff);
        frame(24, 48'hc00000);
        frame(24, 48'h570000);
        frame(24, 48'hb0fdff);
        frame(24, 48'he00000);
        frame(24, 48'hd90000);
        frame(24, 48'hfa1234);
        frame(24, 48'h73ffff);
        frame(24, 48'h200000);
        frame(24, 48'h351234);
        frame(24, 48'h950000);
        frame(24, 48'ha00000);
        frame(24, 48'h000000);
        frame(24, 48'hb00011);
        frame(24, 48'h100000);
        frame(24, 48'h000000);
        frame(23, 48'h580123);
        frame(48, 48'hb000aab00155);
        frame(24, 48'he30000);
        frame(24, 48'hf00000);
        frame(0, 48'h0);
        frame(24, 48'h30fc0f);
        frame(24, 48'h860000);
        for (int i = 0; i < 40; i++) begin
            v = $random(seed);
            if (v[24]) v[19:16] = 4'h0;
            frame(24, {24'h0, v[23:0]});
        end
        report_and_stop();
    end
endmodule // dpcd_top_bench
`default_nettype wire
